// ===== rtl/ios_input_output_select.sv
`timescale 1ns/1ps
`default_nettype none
// Notes on behaviour
// - With the amplifier always running or fs changes kept off the error flag, a clock source switch leaves the receive error flag alone.
// - Otherwise every clock source switch adds one error pulse to the receive error flag.
// - Moving to the crystal source does not drop the PLL locked condition.
// - With the amplifier stopping on lock, leaving the locked PLL for the crystal waits until the oscillator is stable.
// - In that deferred case the output data switch happens together with the crystal switch, never before.
// - Through-output codes 000 to 100 route inputs 0 to 4, and 000 is the reset value.
// - Through-output code 101 routes input 5 (alt V), 110 input 6 (alt U), 111 the modulator output.
// - The through-output disable bit passes data at 0 (reset) and holds the pin low at 1.
// - The unlock switch bit at 1 switches the demodulator input while the PLL is unlocked; 0 is reset.
// - Each command word follows device address E8 and carries command 6 with two chip address bits.
module ios_input_output_select (
  // Clock and reset
  input wire logic mclk,
  input wire logic rst,
  // Serial control port pins
  input wire logic serClk,
  input wire logic serData,
  input wire logic serEnable,
  input wire logic [1:0] chipAddress,
  // Bi-phase inputs and modulator
  input wire logic [ios_pkg::NUM_RX-1:0] rxInput,
  input wire logic modulatorOutput,
  // Clocking status and settings from neighbouring logic
  input wire logic pllLocked,
  input wire logic oscStable,
  input wire ios_pkg::ios_clk_cfg_t clkCfg,
  input wire logic rawReceiveError,
  // Outputs
  output logic demodData,
  output logic throughOutputPin,
  output logic crystalClockSource,
  output logic outputDataFromXtal,
  output logic receiveErrorFlag,
  output logic pllLockedHeld
);
  logic wordValid;
  logic [ios_pkg::WORD_BITS-1:0] word;
  ios_pkg::ios_cfg_t cfg;
  ios_pkg::ios_cfg_t next_cfg;
  logic [ios_pkg::NUM_RX-1:0] rxMeta;
  logic [ios_pkg::NUM_RX-1:0] next_rxMeta;
  logic [ios_pkg::NUM_RX-1:0] rxSync;
  logic [ios_pkg::NUM_RX-1:0] next_rxSync;
  logic modSync;
  logic next_modSync;
  logic thruPick;
  logic demodPick;
  logic next_demodData;
  logic next_throughOutputPin;
  ios_pkg::ios_src_t srcState;
  ios_pkg::ios_src_t next_srcState;
  logic switchEvent;
  logic wantXtal;
  logic stopOnLock;
  logic next_crystalClockSource;
  logic next_outputDataFromXtal;
  logic errorOnSwitch;
  logic next_receiveErrorFlag;
  logic next_pllLockedHeld;

  ios_serial_rx serialRx (
    .mclk(mclk),
    .rst(rst),
    .serClk(serClk),
    .serData(serData),
    .serEnable(serEnable),
    .chipAddress(chipAddress),
    .wordValid(wordValid),
    .word(word)
  );

  // Shared by both selectors so codes map the same way
  function automatic logic pickSource(input logic [2:0] code,
                                      input logic [ios_pkg::NUM_RX-1:0] rx,
                                      input logic modOut);
    if (code == ios_pkg::SEL_MOD) begin
      pickSource = modOut;
    end else begin
      pickSource = rx[code];
    end
  endfunction

  always_comb begin
    next_cfg = cfg;
    if (wordValid) begin
      next_cfg.throughOutputDisable = word[ios_pkg::DISABLE_BIT];
      next_cfg.throughOutputSelect = word[ios_pkg::THRU_MSB:ios_pkg::THRU_LSB];
      next_cfg.unlockInputSwitch = word[ios_pkg::UNLOCK_BIT];
      next_cfg.demodInputSelect = word[ios_pkg::DEMOD_MSB:ios_pkg::DEMOD_LSB];
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      cfg <= ios_pkg::CFG_RESET;
    end else begin
      cfg <= next_cfg;
    end
  end

  // Input pins are captured twice, the modulator output once, before any selector reads them
  always_comb begin
    next_rxMeta = rxInput;
    next_rxSync = rxMeta;
    next_modSync = modulatorOutput;
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      rxMeta <= '0;
      rxSync <= '0;
      modSync <= 1'b0;
    end else begin
      rxMeta <= next_rxMeta;
      rxSync <= next_rxSync;
      modSync <= next_modSync;
    end
  end

  always_comb begin
    thruPick = pickSource(cfg.throughOutputSelect, rxSync, modSync);
    demodPick = pickSource(cfg.demodInputSelect, rxSync, modSync);
    next_throughOutputPin = 1'b0;
    if (!cfg.throughOutputDisable) begin
      next_throughOutputPin = thruPick;
    end
    // Unlocked with the switch set: demod follows the through path instead
    if (cfg.unlockInputSwitch && !pllLocked) begin
      next_demodData = thruPick;
    end else begin
      next_demodData = demodPick;
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      demodData <= 1'b0;
      throughOutputPin <= 1'b0;
    end else begin
      demodData <= next_demodData;
      throughOutputPin <= next_throughOutputPin;
    end
  end

  // Clock source tracking; the PLL lock is never touched here, only reported
  always_comb begin
    wantXtal = !pllLocked
        || clkCfg.commonClockSourceSelect
        || clkCfg.rSideClockSourceSelect;
    stopOnLock = pllLocked
        && clkCfg.oscAmpOperationMode == ios_pkg::AMP_STOP_ON_LOCK;
    next_srcState = srcState;
    switchEvent = 1'b0;
    case (srcState)
      ios_pkg::SRC_PLL: begin
        if (wantXtal) begin
          if (stopOnLock && !oscStable) begin
            next_srcState = ios_pkg::SRC_WAIT;
          end else begin
            next_srcState = ios_pkg::SRC_XTAL;
            switchEvent = 1'b1;
          end
        end
      end
      ios_pkg::SRC_WAIT: begin
        if (!wantXtal) begin
          next_srcState = ios_pkg::SRC_PLL;
        end else if (oscStable || !stopOnLock) begin
          // Losing lock or leaving stop-on-lock ends the wait as well
          next_srcState = ios_pkg::SRC_XTAL;
          switchEvent = 1'b1;
        end
      end
      ios_pkg::SRC_XTAL: begin
        if (!wantXtal) begin
          next_srcState = ios_pkg::SRC_PLL;
          switchEvent = 1'b1;
        end
      end
      default: begin
        next_srcState = ios_pkg::SRC_PLL;
      end
    endcase
    next_crystalClockSource = (next_srcState == ios_pkg::SRC_XTAL);
    // Data path moves with the clock, never ahead of it
    next_outputDataFromXtal = (next_srcState == ios_pkg::SRC_XTAL);
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      srcState <= ios_pkg::SRC_PLL;
      crystalClockSource <= 1'b0;
      outputDataFromXtal <= 1'b0;
    end else begin
      srcState <= next_srcState;
      crystalClockSource <= next_crystalClockSource;
      outputDataFromXtal <= next_outputDataFromXtal;
    end
  end

  always_comb begin
    errorOnSwitch = clkCfg.oscAmpOperationMode != ios_pkg::AMP_CONTINUOUS
        && clkCfg.fsChangeErrorEnable;
    next_receiveErrorFlag = rawReceiveError;
    if (switchEvent && errorOnSwitch) begin
      next_receiveErrorFlag = 1'b1;
    end // otherwise untouched by the switch
    // Lock is only reported here; no source move ever clears it
    next_pllLockedHeld = pllLocked;
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      receiveErrorFlag <= 1'b0;
      pllLockedHeld <= 1'b0;
    end else begin
      receiveErrorFlag <= next_receiveErrorFlag;
      pllLockedHeld <= next_pllLockedHeld;
    end
  end
endmodule
`default_nettype wire

// ===== rtl/ios_pkg.sv
package ios_pkg;
  // Serial control port framing
  localparam logic [7:0] DEV_ADDR = 8'hE8;
  localparam logic [5:0] CMD_NUM = 6'h06;
  localparam int ADDR_BITS = 8;
  localparam int WORD_BITS = 16;
  localparam int CNT_W = 5;
  localparam logic [CNT_W-1:0] ADDR_CNT = 5'h08;
  localparam logic [CNT_W-1:0] WORD_CNT = 5'h10;
  localparam int CMD_MSB = 7;
  localparam int CMD_LSB = 2;
  localparam int CHIP_LSB = 0;
  // Command word fields
  localparam int DISABLE_BIT = 15;
  localparam int THRU_MSB = 14;
  localparam int THRU_LSB = 12;
  localparam int UNLOCK_BIT = 11;
  localparam int DEMOD_MSB = 10;
  localparam int DEMOD_LSB = 8;
  // Input pins and selector codes
  localparam int NUM_RX = 7;
  localparam logic [2:0] SEL_RX0 = 3'h0;
  localparam logic [2:0] SEL_MOD = 3'h7;
  // Oscillator amplifier modes
  localparam logic [1:0] AMP_CONTINUOUS = 2'h0;
  localparam logic [1:0] AMP_STOP_ON_LOCK = 2'h1;

  typedef struct packed {
    logic throughOutputDisable;
    logic [2:0] throughOutputSelect;
    logic unlockInputSwitch;
    logic [2:0] demodInputSelect;
  } ios_cfg_t;

  localparam ios_cfg_t CFG_RESET = '{1'b0, SEL_RX0, 1'b0, SEL_RX0};

  typedef struct packed {
    logic [1:0] oscAmpOperationMode;
    logic fsChangeErrorEnable;
    logic commonClockSourceSelect;
    logic rSideClockSourceSelect;
  } ios_clk_cfg_t;

  typedef enum logic [2:0] {
    SRC_PLL = 3'b001,
    SRC_WAIT = 3'b010,
    SRC_XTAL = 3'b100
  } ios_src_t;
endpackage

// ===== rtl/ios_serial_rx.sv
`timescale 1ns/1ps
`default_nettype none
module ios_serial_rx (
  // Clock and reset
  input wire logic mclk,
  input wire logic rst,
  // Serial control pins
  input wire logic serClk,
  input wire logic serData,
  input wire logic serEnable,
  // Chip address straps
  input wire logic [1:0] chipAddress,
  // Accepted command word
  output logic wordValid,
  output logic [15:0] word
);
  logic [2:0] clkSync, next_clkSync;
  logic [1:0] datSync, next_datSync;
  logic [2:0] enSync, next_enSync;
  logic [7:0] addrShift, next_addrShift;
  logic [15:0] dataShift, next_dataShift;
  logic [ios_pkg::CNT_W-1:0] addrCnt, next_addrCnt;
  logic [ios_pkg::CNT_W-1:0] dataCnt, next_dataCnt;
  logic [15:0] next_word;
  logic next_wordValid;
  logic clkRise, enRise, enFall;

  always_comb begin
    next_clkSync = {clkSync[1:0], serClk};
    next_datSync = {datSync[0], serData};
    next_enSync = {enSync[1:0], serEnable};
    clkRise = clkSync[1] & ~clkSync[2];
    enRise = enSync[1] & ~enSync[2];
    enFall = ~enSync[1] & enSync[2];
    next_addrShift = addrShift;
    next_dataShift = dataShift;
    next_addrCnt = addrCnt;
    next_dataCnt = dataCnt;
    next_word = word;
    next_wordValid = 1'b0;
    // Address goes in LSB first while enable is low, data while it is high
    if (clkRise && !enSync[1] && addrCnt != ios_pkg::ADDR_CNT) begin
      next_addrShift = {datSync[1], addrShift[7:1]};
      next_addrCnt = addrCnt + 1'b1;
    end
    if (clkRise && enSync[1] && dataCnt != ios_pkg::WORD_CNT) begin
      next_dataShift = {datSync[1], dataShift[15:1]};
      next_dataCnt = dataCnt + 1'b1;
    end
    if (enRise) begin
      next_dataCnt = '0;
    end
    if (enFall) begin
      next_addrCnt = '0;
      // Short or foreign frames are dropped whole, never half applied
      if (addrCnt == ios_pkg::ADDR_CNT && addrShift == ios_pkg::DEV_ADDR
          && dataCnt == ios_pkg::WORD_CNT
          && dataShift[ios_pkg::CMD_MSB:ios_pkg::CMD_LSB] == ios_pkg::CMD_NUM
          && dataShift[ios_pkg::CMD_LSB-1:ios_pkg::CHIP_LSB] == chipAddress) begin
        next_word = dataShift;
        next_wordValid = 1'b1;
      end
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      // Idle serial clock is high; a low reset value would fake a first edge
      clkSync <= '1;
      datSync <= '0;
      enSync <= '0;
      addrShift <= '0;
      dataShift <= '0;
      addrCnt <= '0;
      dataCnt <= '0;
      word <= '0;
      wordValid <= 1'b0;
    end else begin
      clkSync <= next_clkSync;
      datSync <= next_datSync;
      enSync <= next_enSync;
      addrShift <= next_addrShift;
      dataShift <= next_dataShift;
      addrCnt <= next_addrCnt;
      dataCnt <= next_dataCnt;
      word <= next_word;
      wordValid <= next_wordValid;
    end
  end
endmodule
`default_nettype wire

// ===== sim/ios_host_model.sv
`timescale 1ns/1ps
`default_nettype none
module ios_host_model (
  // Clock
  input wire logic mclk,
  // Serial control pins
  output logic serClk,
  output logic serData,
  output logic serEnable
);
  initial begin
    serClk = 1'b1;
    serData = 1'b0;
    serEnable = 1'b0;
  end
  // Each level stands three clocks so the synchronisers see it
  task automatic hold3();
    repeat (3) @(negedge mclk);
  endtask
  // Address with enable low, then data with enable high, both LSB first
  task automatic send(input logic [7:0] addr, input logic [15:0] data);
    logic [23:0] f;
    f = {data, addr};
    serEnable = 1'b0;
    hold3();
    for (int i = 0; i < 24; i++) begin
      if (i == 8) begin
        serEnable = 1'b1;
        hold3();
      end
      serClk = 1'b0;
      serData = f[i];
      hold3();
      serClk = 1'b1;
      hold3();
    end
    serEnable = 1'b0;
    serData = ~serData; // Driven to the inverse of its last bit
    repeat (8) @(negedge mclk);
  endtask
endmodule
`default_nettype wire

// ===== sim/ios_input_output_select_chk.sv
`timescale 1ns/1ps
`default_nettype none
module ios_input_output_select_chk (
  // Clock and reset
  input wire logic mclk,
  input wire logic rst,
  // Clocking status
  input wire logic pllLocked,
  input wire logic oscStable,
  input wire ios_pkg::ios_clk_cfg_t clkCfg,
  input wire logic rawReceiveError,
  // Watched outputs
  input wire logic crystalClockSource,
  input wire logic outputDataFromXtal,
  input wire logic receiveErrorFlag,
  input wire logic pllLockedHeld
);
  default clocking @(posedge mclk); endclocking
  default disable iff (rst);
  logic want, stopLock, swErr;
  assign want = !pllLocked | clkCfg.commonClockSourceSelect | clkCfg.rSideClockSourceSelect;
  assign stopLock = pllLocked && clkCfg.oscAmpOperationMode == ios_pkg::AMP_STOP_ON_LOCK;
  assign swErr = clkCfg.oscAmpOperationMode != ios_pkg::AMP_CONTINUOUS && clkCfg.fsChangeErrorEnable;
  AST_GO_XTAL: assert property (want && !stopLock |=> crystalClockSource)
    else $error("crystal source not taken");
  AST_DEFER: assert property (stopLock && !oscStable && !crystalClockSource |=> !crystalClockSource)
    else $error("switch before oscillator stable");
  AST_DEFER_GO: assert property (stopLock && oscStable && want |=> crystalClockSource)
    else $error("deferred switch missing");
  AST_BACK_PLL: assert property (!want |=> !crystalClockSource)
    else $error("no return to PLL");
  AST_DATA_XTAL: assert property (outputDataFromXtal == crystalClockSource)
    else $error("output data apart from source");
  AST_ERR_KEEP: assert property ($changed(crystalClockSource) && !$past(swErr)
    && !$past(rawReceiveError) |-> !receiveErrorFlag)
    else $error("error flag moved on switch");
  AST_ERR_ONCE: assert property ($changed(crystalClockSource) && $past(swErr)
    |-> receiveErrorFlag
    ##1 (receiveErrorFlag == $past(rawReceiveError) || $changed(crystalClockSource)))
    else $error("switch error not single");
  AST_ERR_PASS: assert property (!$past(rst) && $past(rawReceiveError) |-> receiveErrorFlag)
    else $error("receive error lost");
  AST_LOCK_HELD: assert property (!$past(rst) |-> pllLockedHeld == $past(pllLocked))
    else $error("lock status dropped");
endmodule
bind ios_input_output_select ios_input_output_select_chk chk (.mclk, .rst, .pllLocked,
  .oscStable, .clkCfg, .rawReceiveError, .crystalClockSource, .outputDataFromXtal,
  .receiveErrorFlag, .pllLockedHeld);
`default_nettype wire

// ===== sim/ios_input_output_select_test.sv
`timescale 1ns/1ps
`default_nettype none
module ios_input_output_select_test;
  logic mclk, rst, pllLocked, oscStable, rawReceiveError, modulatorOutput;
  logic serClk, serData, serEnable, demodData, throughOutputPin, crystalClockSource;
  logic outputDataFromXtal, receiveErrorFlag, pllLockedHeld;
  logic [ios_pkg::NUM_RX-1:0] rxInput;
  logic [1:0] chipAddress;
  ios_pkg::ios_clk_cfg_t clkCfg;
  int badCount = 0;
  int checkCount = 0;
  ios_host_model host (.mclk(mclk), .serClk(serClk), .serData(serData), .serEnable(serEnable));
  ios_input_output_select DUT (.mclk(mclk), .rst(rst), .serClk(serClk), .serData(serData),
    .serEnable(serEnable), .chipAddress(chipAddress), .rxInput(rxInput),
    .modulatorOutput(modulatorOutput), .pllLocked(pllLocked), .oscStable(oscStable),
    .clkCfg(clkCfg), .rawReceiveError(rawReceiveError), .demodData(demodData),
    .throughOutputPin(throughOutputPin), .crystalClockSource(crystalClockSource),
    .outputDataFromXtal(outputDataFromXtal), .receiveErrorFlag(receiveErrorFlag),
    .pllLockedHeld(pllLockedHeld));
  initial begin
    mclk = 1'b0;
    forever #2 mclk = ~mclk;
  end
  task automatic finishTest();
    $display("checks %0d mismatches %0d", checkCount, badCount);
    if (badCount == 0 && checkCount > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  initial begin
    repeat (100000) @(posedge mclk);
    badCount++;
    $display("mismatch at %0t: run timed out", $time);
    finishTest();
  end
  task automatic chk(input logic got, input logic exp);
    checkCount++;
    if (got !== exp) begin
      badCount++;
      $display("mismatch at %0t: got %b expected %b", $time, got, exp);
    end
  endtask
  task automatic setCfg(input logic dis, input logic [2:0] thru, input logic unl,
                        input logic [2:0] dem);
    host.send(ios_pkg::DEV_ADDR, {dis, thru, unl, dem, ios_pkg::CMD_NUM, chipAddress});
  endtask
  // Chosen source low and the rest high, then the reverse; a wrong route shows
  task automatic route(input logic [2:0] code, input logic thruSide, input logic pass);
    logic [7:0] src;
    for (int v = 0; v < 2; v++) begin
      src = 8'h01 << code;
      if (v == 0) src = ~src;
      {modulatorOutput, rxInput} = src;
      repeat (4) @(negedge mclk);
      chk(thruSide ? throughOutputPin : demodData, v[0] & pass);
    end
  endtask
  initial begin
    rst = 1'b1;
    pllLocked = 1'b1;
    oscStable = 1'b1;
    rawReceiveError = 1'b0;
    rxInput = '0;
    modulatorOutput = 1'b0;
    chipAddress = 2'h2;
    clkCfg = '0;
    repeat (3) @(negedge mclk);
    rst = 1'b0;
    // No serial audio is routed in, so no clock pairing is owed
    route(3'h0, 1'b1, 1'b1);
    route(3'h0, 1'b0, 1'b1);
    for (int c = 0; c < 8; c++) begin
      setCfg(1'b0, c[2:0], 1'b0, c[2:0]);
      route(c[2:0], 1'b1, 1'b1);
      route(c[2:0], 1'b0, 1'b1);
    end
    setCfg(1'b1, 3'h7, 1'b0, 3'h7);
    route(3'h7, 1'b1, 1'b0);
    host.send(8'hE9, {8'h03, ios_pkg::CMD_NUM, chipAddress});
    host.send(ios_pkg::DEV_ADDR, {8'h03, ios_pkg::CMD_NUM, ~chipAddress});
    route(3'h7, 1'b1, 1'b0);
    route(3'h7, 1'b0, 1'b1);
    // Amplifier stays continuous while the unlock switch is on and the PLL unlocked
    setCfg(1'b0, 3'h5, 1'b1, 3'h1);
    pllLocked = 1'b0;
    route(3'h5, 1'b0, 1'b1);
    pllLocked = 1'b1;
    route(3'h1, 1'b0, 1'b1);
    // Output data muting sits outside this block, so none is selected here
    clkCfg.commonClockSourceSelect = 1'b1;
    repeat (2) @(negedge mclk);
    chk(crystalClockSource, 1'b1);
    chk(pllLockedHeld, 1'b1);
    chk(receiveErrorFlag, 1'b0);
    rawReceiveError = 1'b1;
    @(negedge mclk);
    chk(receiveErrorFlag, 1'b1);
    rawReceiveError = 1'b0;
    @(negedge mclk);
    chk(receiveErrorFlag, 1'b0);
    clkCfg = '{ios_pkg::AMP_STOP_ON_LOCK, 1'b1, 1'b0, 1'b0};
    oscStable = 1'b0;
    repeat (2) @(negedge mclk);
    clkCfg.commonClockSourceSelect = 1'b1;
    repeat (6) @(negedge mclk);
    chk(outputDataFromXtal, 1'b0);
    oscStable = 1'b1;
    @(negedge mclk);
    chk(outputDataFromXtal, 1'b1);
    chk(receiveErrorFlag, 1'b1);
    @(negedge mclk);
    chk(receiveErrorFlag, 1'b0);
    // Back to PLL with fs changes kept off the flag: no error pulse
    clkCfg.fsChangeErrorEnable = 1'b0;
    clkCfg.commonClockSourceSelect = 1'b0;
    @(negedge mclk);
    chk(receiveErrorFlag, 1'b0);
    chk(crystalClockSource, 1'b0);
    rst = 1'b1;
    @(negedge mclk);
    chk(crystalClockSource, 1'b0);
    rst = 1'b0;
    route(3'h0, 1'b1, 1'b1);
    route(3'h0, 1'b0, 1'b1);
    repeat (4) @(negedge mclk);
    finishTest();
  end
endmodule
`default_nettype wire
